// ===== core/sioc_map.vh
`ifndef SIOC_MAP_VH
`define SIOC_MAP_VH

// Register indices; byte address is four times the index.
`define SIOC_IDX_IN_ALLOC_B   16'h3362
`define SIOC_IDX_OUT_ALLOC    16'h3363
`define SIOC_IDX_SEL_LOW      16'h3364
`define SIOC_IDX_SEL_HIGH     16'h3365
`define SIOC_IDX_IN_FILT      16'h3366
`define SIOC_IDX_ALM_FILT     16'h3367
`define SIOC_IDX_INVERT       16'h3368
`define SIOC_IDX_IRQ_STAT     16'h3380
`define SIOC_IDX_IRQ_MASK     16'h3381
`define SIOC_IDX_BUS_DI       16'h3382
`define SIOC_IDX_RESTART      16'h3383
`define SIOC_IDX_IN_STATE     16'h3384
`define SIOC_IDX_OUT_STATE    16'h3385

// Reset values.
`define SIOC_RST_IN_ALLOC_B   16'h0004
`define SIOC_RST_OUT_ALLOC    16'h0210
`define SIOC_RST_FILT         16'h0001
`define SIOC_RST_ZERO         16'h0000
`define SIOC_RST_ACT_ALLOC    4'h4
`define SIOC_RST_ACT_OUT      12'h210

// Accepted ranges.
`define SIOC_MAX_IN_ALLOC     16'h0007
`define SIOC_MAX_OUT_DIGIT    4'hb
`define SIOC_MAX_IN_FILT      16'h03e8
`define SIOC_MAX_ALM_FILT     16'h0003

// Field positions.
`define SIOC_BUS_FN_LSB       16
`define SIOC_BUS_TERM_BIT     24
`define SIOC_EV_INPUT         0
`define SIOC_EV_ALARM         1
`define SIOC_EV_RESTART       2

// Timing: control cycles per alarm filter unit.
`define SIOC_ALM_UNIT         3'h2

`endif

// ===== core/sioc_core.v
// Overview of operation
// - Input allocation B accepts 0..7, resets to 4, selects terminal 3 function.
// - Output allocation holds three digits 0..b, range 0000..0bbb, reset 0210.
// - Output codes 0..8 pick status functions; codes 9, a and b drive low.
// - Bus select low makes functions 0..7 follow bus object bits 16..23.
// - Bus select high makes bus bit 24 replace the last physical terminal.
// - Input filter 0..1000 control cycles, reset 1; larger delays recognition.
// - Alarm filter 0..3 in units of two cycles, reset 1, delays alarm.
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/100ps
`include "sioc_map.vh"

module sioc_core #(
   parameter CTRL_DIV = 10
) (
   // Clock and reset.
   input  wire        clock,
   input  wire        rst,
   // AHB-Lite slave.
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [31:0] hrdata,
   // Physical input terminals and alarm source.
   input  wire [3:0]  in_term,
   input  wire        alarm_in,
   // Status functions for the output pairs.
   input  wire        positioning_complete,
   input  wire        motor_rotating,
   input  wire        servo_ready,
   input  wire        torque_limit_active,
   input  wire        brake_release,
   input  wire        encoder_index,
   input  wire        overtravel,
   input  wire        ready,
   input  wire        torque_detect,
   // Conditioned input functions.
   output wire        servo_on,
   output wire        forward_limit_input,
   output wire        reverse_limit_input,
   output wire        gain_select,
   output wire [1:0]  external_latch_input,
   output reg  [9:0]  func_state,
   // Output terminal pairs and alarm.
   output reg  [2:0]  out_pair,
   output reg         alarm_out,
   output wire        irq
);

   function match;
      input [31:0] addr;
      input [15:0] idx;
      begin
         match = (addr == {14'h0000, idx, 2'b00});
      end
   endfunction

   function digits_ok;
      input [15:0] v;
      begin
         digits_ok = (v[15:12] == 4'h0) && (v[11:8] <= `SIOC_MAX_OUT_DIGIT) &&
                     (v[7:4] <= `SIOC_MAX_OUT_DIGIT) && (v[3:0] <= `SIOC_MAX_OUT_DIGIT);
      end
   endfunction

   // Written settings.
   reg  [15:0] in_alloc_ff;
   reg  [15:0] out_alloc_ff;
   reg  [15:0] sel_lo_ff;
   reg  [15:0] sel_hi_ff;
   reg  [15:0] in_filt_ff;
   reg  [15:0] alm_filt_ff;
   reg  [15:0] invert_ff;
   reg  [31:0] bus_di_ff;
   reg  [2:0]  mask_ff;
   reg  [2:0]  stat_ff;
   // Settings in force since the last restart.
   reg  [3:0]  act_alloc_ff;
   reg  [11:0] act_out_ff;
   reg         act_sel_lo_ff;
   reg         act_sel_hi_ff;
   reg  [3:0]  act_inv_ff;
   // Bus data phase.
   reg         dp_wr_ff;
   reg  [31:0] dp_addr_ff;
   // Control cycle divider.
   reg  [15:0] div_ff;
   wire        tick;
   // Filters.
   reg  [9:0]  cnt_ff [0:3];
   reg  [3:0]  filt_ff;
   reg  [2:0]  alm_cnt_ff;
   reg         restart_ev;

   wire        addr_ok;
   wire        rd_clr;
   wire [3:0]  pre;
   wire [2:0]  alm_th;
   wire [8:0]  stat_vec;
   reg  [9:0]  fn_phys;
   reg  [9:0]  nxt_func;
   reg  [3:0]  nxt_filt;
   reg  [2:0]  nxt_out;
   reg  [31:0] nxt_rdata;
   reg  [2:0]  ev;
   // Each process owns its loop index so that no two processes share a driver.
   integer     i_ff;
   integer     i_nf;
   integer     i_op;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign addr_ok   = hsel && hready && htrans[1];
   assign rd_clr    = addr_ok && !hwrite && match(haddr, `SIOC_IDX_IRQ_STAT);
   assign irq       = |(stat_ff & mask_ff);

   assign tick = (div_ff == 16'h0000);

   always @(posedge clock) begin
      if (rst || tick) begin
         div_ff <= CTRL_DIV[15:0] - 16'h0001;
      end else begin
         div_ff <= div_ff - 16'h0001;
      end
   end

   // Address phase capture; read data is prepared here for the data phase.
   always @(posedge clock) begin
      if (rst) begin
         dp_wr_ff   <= 1'b0;
         dp_addr_ff <= 32'h00000000;
         hrdata     <= 32'h00000000;
      end else begin
         dp_wr_ff <= addr_ok && hwrite;
         if (addr_ok) begin
            dp_addr_ff <= haddr;
            if (!hwrite) begin
               hrdata <= nxt_rdata;
            end
         end
      end
   end

   always @* begin
      nxt_rdata = 32'h00000000;
      if (match(haddr, `SIOC_IDX_IN_ALLOC_B)) begin
         nxt_rdata = {16'h0000, in_alloc_ff};
      end else if (match(haddr, `SIOC_IDX_OUT_ALLOC)) begin
         nxt_rdata = {16'h0000, out_alloc_ff};
      end else if (match(haddr, `SIOC_IDX_SEL_LOW)) begin
         nxt_rdata = {16'h0000, sel_lo_ff};
      end else if (match(haddr, `SIOC_IDX_SEL_HIGH)) begin
         nxt_rdata = {16'h0000, sel_hi_ff};
      end else if (match(haddr, `SIOC_IDX_IN_FILT)) begin
         nxt_rdata = {16'h0000, in_filt_ff};
      end else if (match(haddr, `SIOC_IDX_ALM_FILT)) begin
         nxt_rdata = {16'h0000, alm_filt_ff};
      end else if (match(haddr, `SIOC_IDX_INVERT)) begin
         nxt_rdata = {16'h0000, invert_ff};
      end else if (match(haddr, `SIOC_IDX_IRQ_STAT)) begin
         nxt_rdata = {29'h00000000, stat_ff};
      end else if (match(haddr, `SIOC_IDX_IRQ_MASK)) begin
         nxt_rdata = {29'h00000000, mask_ff};
      end else if (match(haddr, `SIOC_IDX_BUS_DI)) begin
         nxt_rdata = bus_di_ff;
      end else if (match(haddr, `SIOC_IDX_IN_STATE)) begin
         nxt_rdata = {18'h00000, func_state, filt_ff};
      end else if (match(haddr, `SIOC_IDX_OUT_STATE)) begin
         nxt_rdata = {28'h0000000, alarm_out, out_pair};
      end
   end

   // Register writes in the data phase; out of range values are ignored.
   always @(posedge clock) begin
      restart_ev <= 1'b0;
      if (rst) begin
         in_alloc_ff  <= `SIOC_RST_IN_ALLOC_B;
         out_alloc_ff <= `SIOC_RST_OUT_ALLOC;
         sel_lo_ff    <= `SIOC_RST_ZERO;
         sel_hi_ff    <= `SIOC_RST_ZERO;
         in_filt_ff   <= `SIOC_RST_FILT;
         alm_filt_ff  <= `SIOC_RST_FILT;
         invert_ff    <= `SIOC_RST_ZERO;
         bus_di_ff    <= 32'h00000000;
         mask_ff      <= 3'h0;
      end else if (dp_wr_ff) begin
         if (match(dp_addr_ff, `SIOC_IDX_IN_ALLOC_B) &&
             hwdata[15:0] <= `SIOC_MAX_IN_ALLOC) begin
            in_alloc_ff <= hwdata[15:0];
         end
         if (match(dp_addr_ff, `SIOC_IDX_OUT_ALLOC) && digits_ok(hwdata[15:0])) begin
            out_alloc_ff <= hwdata[15:0];
         end
         if (match(dp_addr_ff, `SIOC_IDX_SEL_LOW)) begin
            sel_lo_ff <= hwdata[15:0];
         end
         if (match(dp_addr_ff, `SIOC_IDX_SEL_HIGH)) begin
            sel_hi_ff <= hwdata[15:0];
         end
         if (match(dp_addr_ff, `SIOC_IDX_IN_FILT) &&
             hwdata[15:0] <= `SIOC_MAX_IN_FILT) begin
            in_filt_ff <= hwdata[15:0];
         end
         if (match(dp_addr_ff, `SIOC_IDX_ALM_FILT) &&
             hwdata[15:0] <= `SIOC_MAX_ALM_FILT) begin
            alm_filt_ff <= hwdata[15:0];
         end
         if (match(dp_addr_ff, `SIOC_IDX_INVERT)) begin
            invert_ff <= hwdata[15:0];
         end
         if (match(dp_addr_ff, `SIOC_IDX_BUS_DI)) begin
            bus_di_ff <= hwdata;
         end
         if (match(dp_addr_ff, `SIOC_IDX_IRQ_MASK)) begin
            mask_ff <= hwdata[2:0];
         end
         if (match(dp_addr_ff, `SIOC_IDX_RESTART) && hwdata[0]) begin
            restart_ev <= 1'b1;
         end
      end
   end

   // Restart copies the written settings into the active set.
   always @(posedge clock) begin
      if (rst) begin
         act_alloc_ff  <= `SIOC_RST_ACT_ALLOC;
         act_out_ff    <= `SIOC_RST_ACT_OUT;
         act_sel_lo_ff <= 1'b0;
         act_sel_hi_ff <= 1'b0;
         act_inv_ff    <= 4'h0;
      end else if (restart_ev) begin
         act_alloc_ff  <= in_alloc_ff[3:0];
         act_out_ff    <= out_alloc_ff[11:0];
         act_sel_lo_ff <= sel_lo_ff[0];
         act_sel_hi_ff <= sel_hi_ff[0];
         act_inv_ff    <= {invert_ff[12], invert_ff[8], invert_ff[4], invert_ff[0]};
      end
   end

   // Inversion, then bus replacement of the last terminal.
   assign pre[2:0] = in_term[2:0] ^ act_inv_ff[2:0];
   assign pre[3]   = act_sel_hi_ff ? bus_di_ff[`SIOC_BUS_TERM_BIT] :
                     (in_term[3] ^ act_inv_ff[3]);

   // Input filters: count stable control cycles of a differing level.
   always @(posedge clock) begin
      if (rst) begin
         filt_ff <= 4'h0;
         for (i_ff = 0; i_ff < 4; i_ff = i_ff + 1) begin
            cnt_ff[i_ff] <= 10'h000;
         end
      end else if (tick) begin
         filt_ff <= nxt_filt;
         for (i_ff = 0; i_ff < 4; i_ff = i_ff + 1) begin
            if (pre[i_ff] == filt_ff[i_ff] || nxt_filt[i_ff] != filt_ff[i_ff]) begin
               cnt_ff[i_ff] <= 10'h000;
            end else begin
               cnt_ff[i_ff] <= cnt_ff[i_ff] + 10'h001;
            end
         end
      end
   end

   always @* begin
      nxt_filt = filt_ff;
      for (i_nf = 0; i_nf < 4; i_nf = i_nf + 1) begin
         if (pre[i_nf] != filt_ff[i_nf] &&
             {6'h00, cnt_ff[i_nf]} + 16'h0001 >= in_filt_ff) begin
            nxt_filt[i_nf] = pre[i_nf];
         end
      end
   end

   // Terminals 0..2 carry functions 0..2; terminal 3 is allocated.
   always @* begin
      fn_phys = 10'h000;
      fn_phys[0] = filt_ff[0];
      fn_phys[1] = filt_ff[1];
      fn_phys[2] = filt_ff[2];
      if (act_alloc_ff <= 4'h9) begin
         fn_phys[act_alloc_ff] = fn_phys[act_alloc_ff] | filt_ff[3];
      end
      nxt_func = fn_phys;
      if (act_sel_lo_ff) begin
         nxt_func[7:0] = bus_di_ff[`SIOC_BUS_FN_LSB +: 8];
      end
   end

   assign servo_on             = func_state[0];
   assign forward_limit_input  = func_state[1];
   assign reverse_limit_input  = func_state[2];
   assign gain_select          = func_state[5];
   assign external_latch_input = func_state[9:8];

   // Output pairs select status functions by digit.
   assign stat_vec = {torque_detect, ready, overtravel, encoder_index, brake_release,
                      torque_limit_active, servo_ready, motor_rotating,
                      positioning_complete};

   always @* begin
      nxt_out = 3'h0;
      for (i_op = 0; i_op < 3; i_op = i_op + 1) begin
         case (act_out_ff[4 * i_op +: 4])
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8: begin
               nxt_out[i_op] = stat_vec[act_out_ff[4 * i_op +: 4]];
            end
            default: begin
               nxt_out[i_op] = 1'b0;
            end
         endcase
      end
   end

   // Alarm filter in units of two control cycles.
   assign alm_th = alm_filt_ff[1:0] * `SIOC_ALM_UNIT;

   always @(posedge clock) begin
      if (rst) begin
         func_state <= 10'h000;
         out_pair   <= 3'h0;
         alarm_out  <= 1'b0;
         alm_cnt_ff <= 3'h0;
      end else if (tick) begin
         func_state <= nxt_func;
         out_pair   <= nxt_out;
         if (alarm_in == alarm_out) begin
            alm_cnt_ff <= 3'h0;
         end else if (alm_cnt_ff + 3'h1 >= alm_th) begin
            alarm_out  <= alarm_in;
            alm_cnt_ff <= 3'h0;
         end else begin
            alm_cnt_ff <= alm_cnt_ff + 3'h1;
         end
      end
   end

   // Sticky events; a new event wins over the read that clears.
   always @* begin
      ev = 3'h0;
      ev[`SIOC_EV_INPUT]   = tick && (nxt_filt != filt_ff);
      ev[`SIOC_EV_ALARM]   = tick && (alarm_in != alarm_out) &&
                             (alm_cnt_ff + 3'h1 >= alm_th);
      ev[`SIOC_EV_RESTART] = restart_ev;
   end

   always @(posedge clock) begin
      if (rst) begin
         stat_ff <= 3'h0;
      end else begin
         stat_ff <= (rd_clr ? 3'h0 : stat_ff) | ev;
      end
   end

endmodule // sioc_core

// ===== testbench/sioc_checker.sv
`timescale 1ns/100ps
module sioc_checker #(
   parameter CTRL_DIV = 10
) (
   // Clock and reset.
   input wire        clock,
   input wire        rst,
   // Bus.
   input wire        hsel,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire        hready,
   input wire        hreadyout,
   input wire        hresp,
   input wire [31:0] hrdata,
   // Field side.
   input wire        alarm_in,
   input wire        servo_on,
   input wire        forward_limit_input,
   input wire        reverse_limit_input,
   input wire        gain_select,
   input wire [1:0]  external_latch_input,
   input wire [9:0]  func_state,
   input wire [2:0]  out_pair,
   input wire        alarm_out
);
   reg  [15:0] cnt_ff;
   wire [15:0] nxt_cnt = (cnt_ff == CTRL_DIV - 1) ? 16'h0 : cnt_ff + 16'h1;
   wire        tick_seen = (cnt_ff == 16'h0);
   always @(posedge clock) begin
      if (rst) cnt_ff <= 16'h0;
      else cnt_ff <= nxt_cnt;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   property p_alias;
      {external_latch_input, gain_select, reverse_limit_input, forward_limit_input, servo_on}
         == {func_state[9:8], func_state[5], func_state[2:0]};
   endproperty
   property p_fs_tick; $changed(func_state) |-> tick_seen; endproperty
   property p_op_tick; $changed(out_pair) |-> tick_seen; endproperty
   property p_al_tick; $changed(alarm_out) |-> tick_seen; endproperty
   property p_al_rise; $rose(alarm_out) |-> $past(alarm_in); endproperty
   property p_al_fall; $fell(alarm_out) |-> !$past(alarm_in); endproperty
   property p_okay; hreadyout && !hresp; endproperty
   property p_hrd;
      $changed(hrdata) |-> $past(hsel && hready && htrans[1] && !hwrite);
   endproperty
   a_alias: assert property (p_alias) else $error("function alias mismatch");
   a_fs_tick: assert property (p_fs_tick) else $error("input state off tick");
   a_op_tick: assert property (p_op_tick) else $error("output pair off tick");
   a_al_tick: assert property (p_al_tick) else $error("alarm off tick");
   a_al_rise: assert property (p_al_rise) else $error("alarm rose without cause");
   a_al_fall: assert property (p_al_fall) else $error("alarm fell without cause");
   a_okay: assert property (p_okay) else $error("bus not ready or error");
   a_hrd: assert property (p_hrd) else $error("read data changed without read");
   c_alarm: cover property ($rose(alarm_out));
   c_pair: cover property ($changed(out_pair));
   c_servo: cover property ($rose(servo_on));
endmodule // sioc_checker

bind sioc_core sioc_checker #(.CTRL_DIV(CTRL_DIV)) u_chk (.clock, .rst, .hsel, .htrans,
   .hwrite, .hready, .hreadyout, .hresp, .hrdata, .alarm_in, .servo_on, .forward_limit_input,
   .reverse_limit_input, .gain_select, .external_latch_input, .func_state, .out_pair,
   .alarm_out);

// ===== testbench/sioc_field.sv
`timescale 1ns/100ps
module sioc_field (
   // Clock.
   input  wire       clock,
   // Levels commanded by the bench.
   input  wire [3:0] term_cmd,
   input  wire       alm_cmd,
   input  wire [8:0] stat_cmd,
   // Wiring toward the block.
   output reg  [3:0] in_term = 4'h0,
   output reg        alarm_in = 1'b0,
   output reg  [8:0] stat = 9'h0
);
   // Field levels reach the terminals one clock after the bench commands them.
   always @(posedge clock) begin
      in_term <= term_cmd;
      alarm_in <= alm_cmd;
      stat <= stat_cmd;
   end
endmodule // sioc_field

// ===== testbench/servo_io_signal_conditioning_tb.sv
`timescale 1ns/100ps
`include "sioc_map.vh"
module servo_io_signal_conditioning_tb;
   localparam D = 2;
   localparam [111:0] RV = {16'h0, 16'h1, 16'h1, 16'h0, 16'h0, 16'h210, 16'h4};
   reg         clock = 1'b0;
   reg         rst = 1'b1;
   reg         hsel = 1'b0;
   reg  [31:0] haddr = 32'h0;
   reg  [1:0]  htrans = 2'h0;
   reg         hwrite = 1'b0;
   reg  [31:0] hwdata = 32'h0;
   reg  [3:0]  term_cmd = 4'h0;
   reg         alm_cmd = 1'b0;
   reg  [8:0]  stat_cmd = 9'h0;
   reg  [31:0] rd, rv;
   wire [3:0]  in_term;
   wire [8:0]  stat;
   wire [31:0] hrdata;
   wire [9:0]  func_state;
   wire [2:0]  out_pair;
   wire        alarm_in, hreadyout, servo_on, gain_select, alarm_out, irq;
   integer     n_fail = 0, cmp_count = 0, i;
   always #50 clock = ~clock;
   sioc_field fld (.clock(clock), .term_cmd(term_cmd), .alm_cmd(alm_cmd), .stat_cmd(stat_cmd),
      .in_term(in_term), .alarm_in(alarm_in), .stat(stat));
   sioc_core #(.CTRL_DIV(D)) dut (.clock, .rst, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp(), .hrdata, .in_term,
      .alarm_in, .positioning_complete(stat[0]), .motor_rotating(stat[1]),
      .servo_ready(stat[2]), .torque_limit_active(stat[3]), .brake_release(stat[4]),
      .encoder_index(stat[5]), .overtravel(stat[6]), .ready(stat[7]),
      .torque_detect(stat[8]), .servo_on, .forward_limit_input(), .reverse_limit_input(),
      .gain_select, .external_latch_input(), .func_state, .out_pair, .alarm_out, .irq);
   function [2:0] pair_exp(input [3:0] c, input [8:0] s);
      pair_exp = (c <= 4'h8) ? {3{s[c]}} : 3'h0;
   endfunction
   task chk(input [31:0] got, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task xfer(input w, input [15:0] idx, input [31:0] v);
      begin
         @(posedge clock);
         hsel <= 1'b1;
         htrans <= 2'h2;
         hwrite <= w;
         haddr <= {14'h0, idx, 2'h0};
         @(posedge clock);
         while (hreadyout !== 1'b1) @(posedge clock);
         htrans <= 2'h0;
         hwdata <= v;
         @(posedge clock);
         while (hreadyout !== 1'b1) @(posedge clock);
         rd = hrdata;
      end
   endtask
   task wchk(input [15:0] idx, input [31:0] v, input [31:0] e);
      begin
         xfer(1'b1, idx, v);
         xfer(1'b0, idx, 32'h0);
         chk(rd, e);
      end
   endtask
   task rs;
      xfer(1'b1, `SIOC_IDX_RESTART, 32'h1);
   endtask
   task tk(input integer n);
      repeat (n * D) @(posedge clock);
   endtask
   task end_sim;
      begin
         $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
         if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
         else $display("Run complete: FAIL");
         $finish;
      end
   endtask
   initial begin
      #500000;
      n_fail = n_fail + 1;
      end_sim;
   end
   initial begin
      rv = $urandom(32'h871d);
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      for (i = 0; i < 7; i = i + 1) begin
         xfer(1'b0, `SIOC_IDX_IN_ALLOC_B + i[15:0], 32'h0);
         chk(rd, {16'h0, RV[i*16 +: 16]});
      end
      xfer(1'b0, 16'h3390, 32'h0);
      chk(rd, 32'h0);
      wchk(`SIOC_IDX_IN_ALLOC_B, 32'h8, 32'h4);
      wchk(`SIOC_IDX_OUT_ALLOC, 32'hc00, 32'h210);
      wchk(`SIOC_IDX_IN_FILT, 32'h3e9, 32'h1);
      wchk(`SIOC_IDX_ALM_FILT, 32'h4, 32'h1);
      wchk(`SIOC_IDX_IN_FILT, 32'h3e8, 32'h3e8);
      wchk(`SIOC_IDX_OUT_ALLOC, 32'hbbb, 32'hbbb);
      rv = $urandom;
      stat_cmd <= rv[8:0];
      tk(4);
      chk(out_pair, {rv[2], rv[1], rv[0]});
      for (i = 11; i >= 0; i = i - 1) begin
         rv = $urandom;
         stat_cmd <= rv[8:0];
         xfer(1'b1, `SIOC_IDX_OUT_ALLOC, {20'h0, i[3:0], i[3:0], i[3:0]});
         rs;
         tk(4);
         chk(out_pair, pair_exp(i[3:0], rv[8:0]));
      end
      wchk(`SIOC_IDX_IN_FILT, 32'h3, 32'h3);
      term_cmd <= 4'h1;
      tk(2);
      term_cmd <= 4'h0;
      tk(6);
      chk(servo_on, 32'h0);
      term_cmd <= 4'h1;
      tk(1);
      chk(servo_on, 32'h0);
      tk(6);
      chk(servo_on, 32'h1);
      xfer(1'b1, `SIOC_IDX_INVERT, 32'h1);
      tk(6);
      chk(servo_on, 32'h1);
      rs;
      tk(6);
      chk(servo_on, 32'h0);
      term_cmd <= 4'h9;
      wchk(`SIOC_IDX_IN_ALLOC_B, 32'h5, 32'h5);
      rs;
      tk(8);
      chk(gain_select, 32'h1);
      xfer(1'b1, `SIOC_IDX_SEL_HIGH, 32'h1);
      xfer(1'b1, `SIOC_IDX_BUS_DI, 32'h0);
      rs;
      tk(8);
      chk(gain_select, 32'h0);
      xfer(1'b1, `SIOC_IDX_BUS_DI, 32'h0100_0000);
      tk(8);
      chk(gain_select, 32'h1);
      xfer(1'b1, `SIOC_IDX_SEL_LOW, 32'h1);
      rs;
      for (i = 0; i < 3; i = i + 1) begin
         rv = $urandom;
         xfer(1'b1, `SIOC_IDX_BUS_DI, rv);
         tk(4);
         chk(func_state[7:0], rv[23:16]);
      end
      xfer(1'b1, `SIOC_IDX_IRQ_MASK, 32'h0);
      wchk(`SIOC_IDX_ALM_FILT, 32'h0, 32'h0);
      xfer(1'b0, `SIOC_IDX_IRQ_STAT, 32'h0);
      chk(rd & 32'h4, 32'h4);
      alm_cmd <= 1'b1;
      tk(3);
      chk(alarm_out, 32'h1);
      chk(irq, 32'h0);
      xfer(1'b1, `SIOC_IDX_ALM_FILT, 32'h3);
      alm_cmd <= 1'b0;
      tk(4);
      chk(alarm_out, 32'h1);
      tk(6);
      chk(alarm_out, 32'h0);
      xfer(1'b0, `SIOC_IDX_IRQ_STAT, 32'h0);
      chk(rd & 32'h2, 32'h2);
      xfer(1'b0, `SIOC_IDX_IRQ_STAT, 32'h0);
      chk(rd, 32'h0);
      xfer(1'b1, `SIOC_IDX_IRQ_MASK, 32'h2);
      xfer(1'b1, `SIOC_IDX_ALM_FILT, 32'h0);
      alm_cmd <= 1'b1;
      tk(3);
      chk(irq, 32'h1);
      xfer(1'b0, `SIOC_IDX_IRQ_STAT, 32'h0);
      @(posedge clock);
      chk(irq, 32'h0);
      xfer(1'b0, `SIOC_IDX_OUT_STATE, 32'h0);
      chk(rd & 32'h8, 32'h8);
      end_sim;
   end
endmodule // servo_io_signal_conditioning_tb
